// ===== fdv_regs.sv
// Floppy vendor configuration registers with pin, write and request gating.
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "fdv_consts.svh"
module fdv_regs
  import fdv_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  ce,
  input  wire logic                  soft_rst,
  input  wire logic [9:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic [31:0]                avs_readdata,
  output logic                       avs_waitrequest,
  input  wire logic                  core_io_wr,
  input  wire logic [2:0]            core_io_ofs,
  output logic                       core_io_wr_ok,
  input  wire logic                  core_irq,
  input  wire logic                  core_drq,
  input  wire logic                  core_dma_en,
  input  wire logic                  core_pwr_down,
  output logic                       fdc_irq,
  output logic                       fdc_drq,
  input  wire logic [1:0]            core_drive_select_n,
  input  wire logic [1:0]            core_motor_on_n,
  input  wire logic [1:0]            core_density,
  input  wire logic [3:0]            core_misc,
  output logic [`FDV_NPIN-1:0]       fdd_pin_o,
  output logic [`FDV_NPIN-1:0]       fdd_pin_oe,
  input  wire logic [`FDV_NPP-1:0]   pp_pin_i,
  output logic [`FDV_NPP-1:0]        pp_pin_o,
  output logic [`FDV_NPP-1:0]        pp_pin_oe,
  output logic                       compat_mode,
  output logic                       non_burst_dma,
  output logic                       encoding_flag,
  output logic                       iface_ident,
  output logic                       drive_swap,
  output logic                       core_shutdown,
  output logic [1:0]                 boot_drive,
  output logic [7:0]                 drive_types,
  output logic [1:0]                 drive0_type,
  output logic [1:0]                 drive0_rate_table,
  output logic                       drive0_precomp_off,
  output logic [1:0]                 drive1_type,
  output logic [1:0]                 drive1_rate_table,
  output logic                       drive1_precomp_off
);

  fdv_bus_state_t        state_reg;
  logic                  wait_reg;
  logic [31:0]           rdata_reg;
  fdv_byte_t             mode_reg;
  fdv_byte_t             opt_reg;
  fdv_byte_t             type_reg;
  fdv_byte_t             drv_reg [2];
  fdv_byte_t             rd_byte;
  fdv_byte_t             wdata;
  logic [7:0]            idx;
  logic                  req;
  logic                  wr_hit;
  logic                  shut;
  logic                  push;
  logic                  tri_all;
  logic [1:0]            sel_n;
  logic [1:0]            mtr_n;
  logic [1:0]            den;
  logic [`FDV_NPIN-1:0]  pin_val;
  logic [`FDV_NPIN-1:0]  pin_o_reg;
  logic [`FDV_NPIN-1:0]  pin_oe_reg;
  logic [`FDV_NPP-1:0]   pp_o_reg;
  logic [`FDV_NPP-1:0]   pp_oe_reg;
  logic                  io_allowed;
  logic                  io_ok_reg;
  logic                  irq_reg;
  logic                  drq_reg;

  assign idx     = avs_address[9:2];
  assign wdata   = avs_writedata[7:0];
  assign req     = avs_read | avs_write;
  assign wr_hit  = ce & avs_write & avs_byteenable[0] & (state_reg == FDV_ACK);
  assign shut    = mode_reg[`FDV_B_SHUT];
  assign push    = mode_reg[`FDV_B_PUSH];
  assign tri_all = mode_reg[`FDV_B_TRI];

  // Every request gets exactly one cycle with waitrequest low, so reads cost no extra state.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= FDV_IDLE;
      wait_reg  <= 1'b1;
    end else if (ce) begin
      case (state_reg)
        FDV_IDLE: begin
          if (req) begin
            state_reg <= FDV_ACK;
            wait_reg  <= 1'b0;
          end
        end
        FDV_ACK: begin
          state_reg <= FDV_IDLE;
          wait_reg  <= 1'b1;
        end
        default: begin
          state_reg <= FDV_IDLE;
          wait_reg  <= 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      `FDV_IDX_MODE: rd_byte = mode_reg;
      `FDV_IDX_OPT:  rd_byte = opt_reg;
      `FDV_IDX_TYPE: rd_byte = type_reg;
      `FDV_IDX_RSVD: rd_byte = 8'h00;
      `FDV_IDX_DRV0: rd_byte = drv_reg[0];
      `FDV_IDX_DRV1: rd_byte = drv_reg[1];
      default:       rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0;
    end else if (ce && state_reg == FDV_IDLE && avs_read) begin
      rdata_reg <= {24'h0, rd_byte};
    end
  end

  // The soft reset input is deliberately not used here; only rst_n restores defaults.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `FDV_RST_MODE;
      opt_reg  <= `FDV_RST_OPT;
      type_reg <= `FDV_RST_TYPE;
    end else if (wr_hit) begin
      if (idx == `FDV_IDX_MODE) begin
        mode_reg <= wdata;
      end
      if (idx == `FDV_IDX_OPT) begin
        opt_reg <= wdata & `FDV_MASK_OPT;
      end
      if (idx == `FDV_IDX_TYPE) begin
        type_reg <= wdata;
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_drv
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        drv_reg[g] <= `FDV_RST_DRV;
      end else if (wr_hit && idx == 8'(`FDV_IDX_DRV0 + g)) begin
        drv_reg[g] <= wdata & `FDV_MASK_DRV;
      end
    end
  end

  always_comb begin
    sel_n = core_drive_select_n;
    mtr_n = core_motor_on_n;
    den   = core_density;
    if (mode_reg[`FDV_B_SWAP]) begin
      sel_n = {core_drive_select_n[0], core_drive_select_n[1]};
      mtr_n = {core_motor_on_n[0], core_motor_on_n[1]};
    end
    if (opt_reg[`FDV_B_DEN_HI:`FDV_B_DEN_LO] == `FDV_DEN_FORCE_ONE) begin
      den = 2'b11;
    end else if (opt_reg[`FDV_B_DEN_HI:`FDV_B_DEN_LO] == `FDV_DEN_FORCE_ZERO) begin
      den = 2'b00;
    end
    pin_val = {core_misc, den, mtr_n, sel_n};
  end

  // Open-drain pins only ever pull low, so a high level is left to the board pull-up.
  for (genvar i = 0; i < `FDV_NPIN; i++) begin : g_pin
    logic drive_en;
    assign drive_en = !tri_all && (!shut || i < `FDV_NKEEP);
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        pin_o_reg[i]  <= 1'b0;
        pin_oe_reg[i] <= 1'b0;
      end else if (ce) begin
        if (push) begin
          pin_o_reg[i]  <= pin_val[i];
          pin_oe_reg[i] <= drive_en;
        end else begin
          pin_o_reg[i]  <= 1'b0;
          pin_oe_reg[i] <= drive_en & ~pin_val[i];
        end
      end
    end
  end

  // The parallel-port floppy pins ignore driver type and tri-state control.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pp_o_reg  <= '0;
      pp_oe_reg <= '0;
    end else if (ce) begin
      pp_o_reg  <= pp_pin_i;
      pp_oe_reg <= {`FDV_NPP{!shut}};
    end
  end

  always_comb begin
    io_allowed = !shut;
    case (core_io_ofs)
      `FDV_IO_DIGITAL_OUTPUT: io_allowed = 1'b1;
      `FDV_IO_TAPE_DRIVE:     io_allowed = 1'b1;
      `FDV_IO_RATE_SELECT:    io_allowed = 1'b1;
      `FDV_IO_CONFIG_CONTROL: io_allowed = 1'b1;
      default:                io_allowed = !shut;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      io_ok_reg <= 1'b0;
    end else if (ce) begin
      io_ok_reg <= core_io_wr & io_allowed;
    end
  end

  // Shutdown counts as disabled, so requests stay quiet while the core is off.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= 1'b0;
      drq_reg <= 1'b0;
    end else if (ce) begin
      irq_reg <= core_irq & core_dma_en & ~core_pwr_down & ~shut;
      drq_reg <= core_drq & core_dma_en & ~core_pwr_down & ~shut;
    end
  end

  assign avs_readdata       = rdata_reg;
  assign avs_waitrequest    = wait_reg;
  assign core_io_wr_ok      = io_ok_reg;
  assign fdc_irq            = irq_reg;
  assign fdc_drq            = drq_reg;
  assign fdd_pin_o          = pin_o_reg;
  assign fdd_pin_oe         = pin_oe_reg;
  assign pp_pin_o           = pp_o_reg;
  assign pp_pin_oe          = pp_oe_reg;
  assign compat_mode        = mode_reg[`FDV_B_COMPAT];
  assign non_burst_dma      = mode_reg[`FDV_B_NOBURST];
  assign encoding_flag      = mode_reg[`FDV_B_ENC];
  assign iface_ident        = mode_reg[`FDV_B_IDENT];
  assign drive_swap         = mode_reg[`FDV_B_SWAP];
  assign core_shutdown      = mode_reg[`FDV_B_SHUT];
  assign boot_drive         = opt_reg[`FDV_B_BOOT_HI:`FDV_B_BOOT_LO];
  assign drive_types        = type_reg;
  assign drive0_type        = drv_reg[0][1:0];
  assign drive0_rate_table  = drv_reg[0][4:3];
  assign drive0_precomp_off = drv_reg[0][`FDV_B_PRECOMP];
  assign drive1_type        = drv_reg[1][1:0];
  assign drive1_rate_table  = drv_reg[1][4:3];
  assign drive1_precomp_off = drv_reg[1][`FDV_B_PRECOMP];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  soft_keep_a:
    assert property (soft_rst && !wr_hit |=> $stable(mode_reg) && $stable(type_reg))
    else $error("soft reset changed a register");
  mode_write_a:
    assert property (wr_hit && idx == `FDV_IDX_MODE |=> mode_reg == $past(wdata))
    else $error("mode write not stored");
  opt_rsvd_a:
    assert property ((opt_reg & ~`FDV_MASK_OPT) == 8'h00)
    else $error("option reserved bits set");
  drv_rsvd_a:
    assert property ((drv_reg[0] & ~`FDV_MASK_DRV) == 8'h00)
    else $error("drive reserved bits set");
  rsvd_read_a:
    assert property (ce && state_reg == FDV_IDLE && avs_read && idx == `FDV_IDX_RSVD
                     |=> avs_readdata == 32'h0 && !avs_waitrequest)
    else $error("reserved index read not zero");
  tri_all_a:
    assert property (ce && tri_all |=> fdd_pin_oe == '0)
    else $error("pins driven while tri-stated");
  shut_keep_a:
    assert property (ce && shut && !tri_all && push
                     |=> fdd_pin_oe == {{(`FDV_NPIN-`FDV_NKEEP){1'b0}}, {`FDV_NKEEP{1'b1}}})
    else $error("shutdown pin drive wrong");
  open_drain_a:
    assert property (ce && !push && !tri_all && !shut
                     |=> fdd_pin_o == '0 && fdd_pin_oe == ~$past(pin_val))
    else $error("open-drain drive wrong");
  swap_a:
    assert property (ce && push && mode_reg[`FDV_B_SWAP] && !tri_all
                     |=> fdd_pin_o[1:0] == {$past(core_drive_select_n[0]),
                                            $past(core_drive_select_n[1])})
    else $error("drive selects not swapped");
  den_force_a:
    assert property (ce && push && opt_reg[3:2] == `FDV_DEN_FORCE_ZERO
                     |=> fdd_pin_o[5:4] == 2'b00)
    else $error("density not forced low");
  pp_free_a:
    assert property (ce && !shut |=> pp_pin_oe == '1 && pp_pin_o == $past(pp_pin_i))
    else $error("parallel-port pins affected");
  io_gate_a:
    assert property (ce && shut && core_io_wr && core_io_ofs == 3'h5 |=> !core_io_wr_ok)
    else $error("write passed during shutdown");
  req_off_a:
    assert property (ce && core_pwr_down |=> !fdc_irq && !fdc_drq)
    else $error("request while powered down");
  wait_one_a:
    assert property (ce && state_reg == FDV_IDLE && req |=> !avs_waitrequest)
    else $error("request not answered");

  read_c: cover property (avs_read && !avs_waitrequest);
  write_c: cover property (wr_hit && idx == `FDV_IDX_DRV1);
  shut_c: cover property (shut && core_io_wr ##1 core_io_wr_ok);
  swap_c: cover property (mode_reg[`FDV_B_SWAP] && push && !tri_all);

endmodule

// ===== fdv_consts.svh
// Constants for the floppy vendor configuration register bank.
// How it works
// - Only the hard reset loads defaults; soft reset leaves every register untouched.
// - Mode bit 0 picks normal floppy mode or enhanced mode 2.
// - Mode bit 1 picks burst DMA at 0, non-burst DMA at 1.
// - Mode bits 3:2 pick the interface mode; 10 is reserved.
// - Mode bit 4 swaps drive and motor selects of drives 0 and 1.
// - Mode bit 5 shuts the core down; only four I/O registers accept writes.
// - In shutdown all pins float except density, drive and motor selects.
// - Mode bit 6 picks open-drain at 0, push-pull at 1.
// - Mode bit 7 floats every floppy output.
// - Mode bits 6 and 7 leave the parallel-port floppy pins alone.
// - Option bits 3:2 leave density alone, force it high, or force low.
// - Type register holds four 2-bit drive types, all reset to ones.
// - Index f3 is read-only and always reads zero.
// - Per-drive bits 1:0 select the drive type, reset zero.
// - Per-drive bits 4:3 select the data-rate table.
// - Per-drive bit 6 set disables write precompensation.
// - Per-drive bits 2, 5 and 7 are read-only zero.
// - The second per-drive register matches the first in layout and default.
// - Powered down or disabled, interrupt and DMA requests are suppressed.
`ifndef FDV_CONSTS_SVH
`define FDV_CONSTS_SVH
`define FDV_IDX_MODE 8'hf0
`define FDV_IDX_OPT 8'hf1
`define FDV_IDX_TYPE 8'hf2
`define FDV_IDX_RSVD 8'hf3
`define FDV_IDX_DRV0 8'hf4
`define FDV_IDX_DRV1 8'hf5
`define FDV_RST_MODE 8'h0e
`define FDV_RST_OPT 8'h00
`define FDV_RST_TYPE 8'hff
`define FDV_RST_DRV 8'h00
`define FDV_MASK_OPT 8'hcc
`define FDV_MASK_DRV 8'h5b
`define FDV_B_COMPAT 0
`define FDV_B_NOBURST 1
`define FDV_B_ENC 2
`define FDV_B_IDENT 3
`define FDV_B_SWAP 4
`define FDV_B_SHUT 5
`define FDV_B_PUSH 6
`define FDV_B_TRI 7
`define FDV_B_DEN_LO 2
`define FDV_B_DEN_HI 3
`define FDV_B_BOOT_LO 6
`define FDV_B_BOOT_HI 7
`define FDV_B_PRECOMP 6
`define FDV_DEN_FORCE_ONE 2'b10
`define FDV_DEN_FORCE_ZERO 2'b11
`define FDV_IO_DIGITAL_OUTPUT 3'h2
`define FDV_IO_TAPE_DRIVE 3'h3
`define FDV_IO_RATE_SELECT 3'h4
`define FDV_IO_CONFIG_CONTROL 3'h7
`define FDV_NPIN 10
`define FDV_NKEEP 6
`define FDV_NPP 4
`endif

// ===== fdv_pkg.sv
// Types shared by the floppy vendor configuration register bank.
package fdv_pkg;
  typedef enum logic [1:0] {
    FDV_IDLE = 2'b01,
    FDV_ACK  = 2'b10
  } fdv_bus_state_t;
  typedef logic [7:0] fdv_byte_t;
endpackage

// ===== fdv_drive_model.sv
// Drive-side cable model: pulled-up floppy lines and a parallel-port pin source.
`timescale 1ns/1ps
module fdv_drive_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [9:0] pin_o,
  input  wire logic [9:0] pin_oe,
  output logic      [9:0] line,
  output logic      [3:0] pp_src
);
  // The drive end pulls every line up, so a released open-drain line reads one.
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      line[i] = pin_oe[i] ? pin_o[i] : 1'b1;
    end
  end
  // The pins change every cycle so that a stale copy cannot pass for a fresh one.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pp_src <= 4'h5;
    end else begin
      pp_src <= pp_src + 4'h3;
    end
  end
endmodule

// ===== fdv_tb.sv
// Self-checking testbench for the floppy vendor configuration register bank.
`timescale 1ns/1ps
module tb_top;
  import fdv_pkg::*;
  logic       mclk, rst_n, ce, soft_rst, avs_read, avs_write, avs_waitrequest;
  logic       core_io_wr, core_io_wr_ok, core_irq, core_drq, core_dma_en, core_pwr_down;
  logic       fdc_irq, fdc_drq, compat_mode, non_burst_dma, encoding_flag, iface_ident;
  logic       drive_swap, core_shutdown, drive0_precomp_off, drive1_precomp_off;
  logic [9:0] avs_address, fdd_pin_o, fdd_pin_oe, line;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable, core_misc, pp_pin_i, pp_pin_o, pp_pin_oe;
  logic [2:0] core_io_ofs;
  logic [1:0] core_drive_select_n, core_motor_on_n, core_density, boot_drive;
  logic [1:0] drive0_type, drive0_rate_table, drive1_type, drive1_rate_table;
  logic [7:0] drive_types;
  fdv_byte_t  rdv;
  int         failures, tests_run;

  fdv_regs dut (
    .mclk               (mclk),
    .rst_n              (rst_n),
    .ce                 (ce),
    .soft_rst           (soft_rst),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .core_io_wr         (core_io_wr),
    .core_io_ofs        (core_io_ofs),
    .core_io_wr_ok      (core_io_wr_ok),
    .core_irq           (core_irq),
    .core_drq           (core_drq),
    .core_dma_en        (core_dma_en),
    .core_pwr_down      (core_pwr_down),
    .fdc_irq            (fdc_irq),
    .fdc_drq            (fdc_drq),
    .core_drive_select_n(core_drive_select_n),
    .core_motor_on_n    (core_motor_on_n),
    .core_density       (core_density),
    .core_misc          (core_misc),
    .fdd_pin_o          (fdd_pin_o),
    .fdd_pin_oe         (fdd_pin_oe),
    .pp_pin_i           (pp_pin_i),
    .pp_pin_o           (pp_pin_o),
    .pp_pin_oe          (pp_pin_oe),
    .compat_mode        (compat_mode),
    .non_burst_dma      (non_burst_dma),
    .encoding_flag      (encoding_flag),
    .iface_ident        (iface_ident),
    .drive_swap         (drive_swap),
    .core_shutdown      (core_shutdown),
    .boot_drive         (boot_drive),
    .drive_types        (drive_types),
    .drive0_type        (drive0_type),
    .drive0_rate_table  (drive0_rate_table),
    .drive0_precomp_off (drive0_precomp_off),
    .drive1_type        (drive1_type),
    .drive1_rate_table  (drive1_rate_table),
    .drive1_precomp_off (drive1_precomp_off)
  );
  fdv_drive_model drv (.mclk(mclk), .rst_n(rst_n), .pin_o(fdd_pin_o), .pin_oe(fdd_pin_oe),
                       .line(line), .pp_src(pp_pin_i));

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // The request is held until waitrequest is sampled low; only then is it dropped.
  task automatic bus(input logic w, input logic [7:0] i, input fdv_byte_t d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address   <= {i, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write     <= w;
    avs_read      <= ~w;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    rdv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 40) begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] i, input fdv_byte_t d);
    bus(1'b1, i, d);
  endtask

  task automatic rc(input logic [7:0] i, input fdv_byte_t e);
    bus(1'b0, i, 8'h00);
    chk(rdv, e);
  endtask

  // Swap exchanges only the select and motor lines of drives 0 and 1.
  function automatic logic [9:0] pv(input logic sw, input logic [1:0] den);
    if (sw) begin
      return {core_misc, den, core_motor_on_n[0], core_motor_on_n[1],
              core_drive_select_n[0], core_drive_select_n[1]};
    end
    return {core_misc, den, core_motor_on_n, core_drive_select_n};
  endfunction

  task automatic t_reset;
    fdv_byte_t ex[6] = '{8'h0e, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rc(8'hf0 + 8'(i), ex[i]);
    end
    chk({non_burst_dma, encoding_flag, iface_ident, compat_mode}, 4'he);
    chk({drive_swap, core_shutdown}, 2'h0);
    chk(drive_types, 8'hff);
    rc(8'hff, 8'h00);
    $display("done: reset values");
  endtask

  task automatic t_regs;
    wr(8'hf1, 8'hf0);
    rc(8'hf1, 8'hc0);
    wr(8'hf2, 8'h1b);
    rc(8'hf2, 8'h1b);
    // A write with its low byte lane disabled must leave the register alone.
    avs_byteenable <= 4'h0;
    wr(8'hf2, 8'h00);
    avs_byteenable <= 4'h1;
    rc(8'hf2, 8'h1b);
    wr(8'hf3, 8'hff);
    rc(8'hf3, 8'h00);
    wr(8'hf4, 8'hff);
    rc(8'hf4, 8'h5b);
    wr(8'hf5, 8'h48);
    rc(8'hf5, 8'h48);
    wr(8'hef, 8'hff);
    rc(8'hef, 8'h00);
    chk({boot_drive, drive_types}, 10'h31b);
    chk({drive0_type, drive0_rate_table, drive0_precomp_off}, 5'h1f);
    chk({drive1_type, drive1_rate_table, drive1_precomp_off}, 5'h03);
    wr(8'hf1, 8'h00);
    $display("done: register masks");
  endtask

  task automatic t_soft;
    wr(8'hf0, 8'h0f);
    soft_rst <= 1'b1;
    tick(3);
    soft_rst <= 1'b0;
    rc(8'hf0, 8'h0f);
    rc(8'hf5, 8'h48);
    // A hard reset in mid-run must bring the defaults back.
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    rc(8'hf0, 8'h0e);
    rc(8'hf5, 8'h00);
    $display("done: soft reset");
  endtask

  task automatic t_mode;
    fdv_byte_t m;
    for (int b = 0; b < 6; b++) begin
      m = (b == 5) ? 8'h02 : 8'h0e ^ (8'h01 << b);
      wr(8'hf0, m);
      tick(2);
      chk({drive_swap, iface_ident, encoding_flag, non_burst_dma, compat_mode},
          m[4:0]);
    end
    wr(8'hf0, 8'h0e);
    $display("done: mode bits");
  endtask

  task automatic t_pins;
    tick(3);
    chk({fdd_pin_o, line}, {10'h0, pv(1'b0, core_density)});
    wr(8'hf0, 8'h1e);
    tick(3);
    chk(line, pv(1'b1, core_density));
    wr(8'hf0, 8'h5e);
    tick(3);
    chk({fdd_pin_oe, fdd_pin_o}, {10'h3ff, pv(1'b1, core_density)});
    wr(8'hf0, 8'h4e);
    tick(3);
    chk({fdd_pin_oe, fdd_pin_o}, {10'h3ff, pv(1'b0, core_density)});
    wr(8'hf1, 8'h08);
    tick(3);
    chk(fdd_pin_o, pv(1'b0, 2'b11));
    wr(8'hf1, 8'h0c);
    tick(3);
    chk(fdd_pin_o, pv(1'b0, 2'b00));
    wr(8'hf1, 8'h04);
    tick(3);
    chk(fdd_pin_o, pv(1'b0, core_density));
    wr(8'hf1, 8'h00);
    wr(8'hf0, 8'h8e);
    tick(3);
    chk({fdd_pin_oe, line, pp_pin_oe}, {10'h0, 10'h3ff, 4'hf});
    // The cable model steps its source by three each cycle and the pin lags it by one.
    chk(pp_pin_o, 4'(pp_pin_i - 4'h3));
    wr(8'hf0, 8'h0e);
    $display("done: pin drivers");
  endtask

  task automatic t_shut;
    logic [9:0] v;
    v = pv(1'b0, core_density);
    {core_irq, core_drq, core_dma_en, core_io_wr} <= 4'hf;
    wr(8'hf0, 8'h2e);
    tick(3);
    chk({core_shutdown, fdd_pin_oe}, {1'b1, 4'h0, ~v[5:0]});
    chk({pp_pin_oe, fdc_irq, fdc_drq}, 6'h0);
    for (int k = 0; k < 8; k++) begin
      core_io_ofs <= 3'(k);
      tick(2);
      chk(core_io_wr_ok, 1'(k == 2 || k == 3 || k == 4 || k == 7));
    end
    // Push-pull shutdown keeps only the density, select and motor lines driven.
    wr(8'hf0, 8'h6e);
    tick(3);
    chk(fdd_pin_oe, 10'h03f);
    wr(8'hf0, 8'h0e);
    tick(3);
    chk({fdc_irq, fdc_drq, core_io_wr_ok}, 3'h7);
    core_pwr_down <= 1'b1;
    tick(3);
    chk({fdc_irq, fdc_drq}, 2'h0);
    {core_pwr_down, core_dma_en} <= 2'b00;
    tick(3);
    chk({fdc_irq, fdc_drq}, 2'h0);
    {core_irq, core_drq, core_io_wr} <= 3'h0;
    $display("done: shutdown");
  endtask

  // With the clock enable low the write gate must not move at all.
  task automatic t_ce;
    tick(2);
    core_io_ofs <= 3'h0;
    ce          <= 1'b0;
    core_io_wr  <= 1'b1;
    tick(3);
    chk(core_io_wr_ok, 1'b0);
    ce <= 1'b1;
    tick(2);
    chk(core_io_wr_ok, 1'b1);
    core_io_wr <= 1'b0;
    $display("done: clock enable");
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    avs_byteenable = 4'h1;
    {soft_rst, avs_read, avs_write, core_io_wr, core_irq, core_drq} = 6'h0;
    {core_dma_en, core_pwr_down, avs_address, avs_writedata, core_io_ofs} = '0;
    {core_drive_select_n, core_motor_on_n, core_density, core_misc} = 10'h26a;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_soft();
    t_mode();
    t_pins();
    t_shut();
    t_ce();
    stop_test();
  end
endmodule
